// *** term_rx_pkg.sv ***
// Shared codes, levels and parser states for the terminal receive block.
// Assumes 8-bit characters from an external receiver on the same clock.
package term_rx_pkg;
  localparam logic [7:0] CH_ESC    = 8'h1B;
  localparam logic [7:0] CH_XOFF   = 8'h13;
  localparam logic [7:0] CH_XON    = 8'h11;
  localparam logic [7:0] CH_SLASH  = 8'h2F;
  localparam logic [7:0] CH_UP     = 8'h41;
  localparam logic [7:0] CH_DOWN   = 8'h42;
  localparam logic [7:0] CH_RIGHT  = 8'h43;
  localparam logic [7:0] CH_LEFT   = 8'h44;
  localparam logic [7:0] CH_GFX_ON = 8'h46;
  localparam logic [7:0] CH_GFX_OF = 8'h47;
  localparam logic [7:0] CH_HOME   = 8'h48;
  localparam logic [7:0] CH_RLF    = 8'h49;
  localparam logic [7:0] CH_ERA_SC = 8'h4A;
  localparam logic [7:0] CH_ERA_LN = 8'h4B;
  localparam logic [7:0] CH_ADDR   = 8'h59;
  localparam logic [7:0] CH_IDENT  = 8'h5A;
  localparam logic [7:0] CH_KP_ALT = 8'h3D;
  localparam logic [7:0] CH_KP_NUM = 8'h3E;
  localparam logic [7:0] CH_ANSI   = 8'h3C;
  localparam logic [7:0] ADDR_BIAS = 8'h1F;
  localparam logic [6:0] RX_FULL   = 7'h40;
  localparam logic [6:0] XOFF_LVL  = 7'h20;
  localparam logic [6:0] XON_LVL   = 7'h10;
  localparam logic [2:0] KBD_FULL  = 3'h4;
  localparam logic [1:0] ID_LEN    = 2'h3;
  localparam logic [4:0] ROW_TOP   = 5'h01;
  localparam logic [4:0] ROW_BOT   = 5'h18;
  localparam logic [6:0] COL_LEFT  = 7'h01;
  localparam logic [6:0] COL_RIGHT = 7'h50;
  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_ESC    = 5'h02,
    ST_ROW    = 5'h04,
    ST_COL    = 5'h08,
    ST_ANSI   = 5'h10
  } parse_state_t;
endpackage

// *** legacy_escape_rx_flow_control.sv ***
// Receive buffer, legacy escape interpreter and XON/XOFF flow control.
// Assumes receiver, transmitter and keyboard strobes come from logic on i_clk.
`timescale 1ns/100ps
module legacy_escape_rx_flow_control (
  input  logic       i_clk,
  input  logic       i_rst,
  input  logic       i_rx_valid,
  input  logic [7:0] i_rx_data,
  input  logic       i_tx_ready,
  input  logic       i_key_valid,
  input  logic [7:0] i_key_data,
  input  logic       i_hold_key,
  input  logic       i_automatic_flow_control,
  input  logic       i_setup_mode,
  input  logic       i_flush_req,
  input  logic       i_flush_done,
  output logic       o_tx_valid,
  output logic [7:0] o_tx_data,
  output logic       o_char_valid,
  output logic [7:0] o_char_data,
  output logic [4:0] o_cursor_row,
  output logic [6:0] o_cursor_col,
  output logic       o_glyph_graphics,
  output logic       o_alt_keypad,
  output logic       o_ansi_mode,
  output logic       o_erase_screen,
  output logic       o_erase_line,
  output logic       o_scroll_down,
  output logic       o_error_glyph,
  output logic       o_keyboard_locked_indicator,
  output logic       o_key_click_en
);
  logic [7:0] rx_mem [64];
  logic [5:0] wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
  logic [6:0] cnt_q, cnt_d;
  logic       flush_q, flush_d;
  term_rx_pkg::parse_state_t st_q, st_d;
  logic [4:0] row_q, row_d, row_tmp_q, row_tmp_d, row_pick;
  logic [6:0] col_q, col_d, col_pick;
  logic       gfx_q, gfx_d, alt_q, alt_d, ansi_q, ansi_d;
  logic       chv_q, chv_d, era_s_q, era_s_d, era_l_q, era_l_d;
  logic       scr_q, scr_d, err_q, err_d, id_req_q, id_req_d;
  logic [7:0] ch_q, ch_d, rx_head, addr_v;
  logic       rx_ok, push, pop;

  // Flow codes are acted on at arrival and never enter the buffer.
  assign rx_ok   = i_rx_valid && i_rx_data != term_rx_pkg::CH_XOFF && i_rx_data != term_rx_pkg::CH_XON;
  assign push    = rx_ok && cnt_q != term_rx_pkg::RX_FULL && !flush_q;
  assign pop     = cnt_q != 7'h00 && !i_setup_mode && !flush_q;
  assign rx_head = rx_mem[rd_ptr_q];
  assign addr_v  = rx_head - term_rx_pkg::ADDR_BIAS;
  assign row_pick = (rx_head <= term_rx_pkg::ADDR_BIAS) ? term_rx_pkg::ROW_TOP :
                    (addr_v > {3'h0, term_rx_pkg::ROW_BOT}) ? term_rx_pkg::ROW_BOT : addr_v[4:0];
  assign col_pick = (rx_head <= term_rx_pkg::ADDR_BIAS) ? term_rx_pkg::COL_LEFT :
                    (addr_v > {1'h0, term_rx_pkg::COL_RIGHT}) ? term_rx_pkg::COL_RIGHT : addr_v[6:0];

  always_comb begin
    {wr_ptr_d, rd_ptr_d, cnt_d} = {wr_ptr_q, rd_ptr_q, cnt_q};
    {flush_d, gfx_d, alt_d, ansi_d} = {flush_q, gfx_q, alt_q, ansi_q};
    st_d = st_q;
    {row_d, col_d, row_tmp_d, ch_d} = {row_q, col_q, row_tmp_q, ch_q};
    {chv_d, era_s_d, era_l_d, scr_d, id_req_d} = 5'h00;
    err_d = rx_ok && cnt_q == term_rx_pkg::RX_FULL && !flush_q;
    if (pop) begin
      rd_ptr_d = rd_ptr_q + 6'h01;
      cnt_d = cnt_q - 7'h01;
      case (st_q)
        term_rx_pkg::ST_NORMAL: begin
          if (rx_head == term_rx_pkg::CH_ESC) begin
            st_d = term_rx_pkg::ST_ESC;
          end else begin
            chv_d = 1'b1;
            ch_d = rx_head;
          end
        end
        term_rx_pkg::ST_ESC: begin
          st_d = term_rx_pkg::ST_NORMAL;
          case (rx_head)
            term_rx_pkg::CH_UP:     if (row_q > term_rx_pkg::ROW_TOP) row_d = row_q - 5'h01;
            term_rx_pkg::CH_DOWN:   if (row_q < term_rx_pkg::ROW_BOT) row_d = row_q + 5'h01;
            term_rx_pkg::CH_RIGHT:  if (col_q < term_rx_pkg::COL_RIGHT) col_d = col_q + 7'h01;
            term_rx_pkg::CH_LEFT:   if (col_q > term_rx_pkg::COL_LEFT) col_d = col_q - 7'h01;
            term_rx_pkg::CH_GFX_ON: gfx_d = 1'b1;
            term_rx_pkg::CH_GFX_OF: gfx_d = 1'b0;
            term_rx_pkg::CH_HOME: begin
              row_d = term_rx_pkg::ROW_TOP;
              col_d = term_rx_pkg::COL_LEFT;
            end
            term_rx_pkg::CH_RLF: begin
              if (row_q == term_rx_pkg::ROW_TOP) scr_d = 1'b1;
              else row_d = row_q - 5'h01;
            end
            term_rx_pkg::CH_ERA_SC: era_s_d = 1'b1;
            term_rx_pkg::CH_ERA_LN: era_l_d = 1'b1;
            term_rx_pkg::CH_ADDR:   st_d = term_rx_pkg::ST_ROW;
            term_rx_pkg::CH_IDENT:  id_req_d = 1'b1;
            term_rx_pkg::CH_KP_ALT: alt_d = 1'b1;
            term_rx_pkg::CH_KP_NUM: alt_d = 1'b0;
            term_rx_pkg::CH_ANSI: begin
              st_d = term_rx_pkg::ST_ANSI;
              ansi_d = 1'b1;
            end
            // Unlisted escape codes fall here and return the parser to ST_NORMAL.
            default: st_d = term_rx_pkg::ST_NORMAL;
          endcase
        end
        term_rx_pkg::ST_ROW: begin
          row_tmp_d = row_pick;
          st_d = term_rx_pkg::ST_COL;
        end
        term_rx_pkg::ST_COL: begin
          row_d = row_tmp_q;
          col_d = col_pick;
          st_d = term_rx_pkg::ST_NORMAL;
        end
        term_rx_pkg::ST_ANSI: begin
          // The ANSI parser downstream sees every character.
          chv_d = 1'b1;
          ch_d = rx_head;
        end
        default: st_d = term_rx_pkg::ST_NORMAL;
      endcase
    end
    if (push) begin
      wr_ptr_d = wr_ptr_q + 6'h01;
      cnt_d = cnt_d + 7'h01;
    end
    if (i_flush_req) flush_d = 1'b1;
    if (i_flush_done) flush_d = 1'b0;
    if (i_flush_req || flush_q) begin
      wr_ptr_d = 6'h00;
      rd_ptr_d = 6'h00;
      cnt_d = 7'h00;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) rx_mem[wr_ptr_q] <= i_rx_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {wr_ptr_q, rd_ptr_q, cnt_q} <= 19'h00000;
      st_q <= term_rx_pkg::ST_NORMAL;
      {row_q, col_q, row_tmp_q} <= {term_rx_pkg::ROW_TOP, term_rx_pkg::COL_LEFT, term_rx_pkg::ROW_TOP};
      ch_q <= 8'h00;
      {flush_q, gfx_q, alt_q, ansi_q, chv_q, era_s_q, era_l_q, scr_q, err_q, id_req_q} <= 10'h000;
    end else begin
      {wr_ptr_q, rd_ptr_q, cnt_q} <= {wr_ptr_d, rd_ptr_d, cnt_d};
      st_q <= st_d;
      {row_q, col_q, row_tmp_q, ch_q} <= {row_d, col_d, row_tmp_d, ch_d};
      {flush_q, gfx_q, alt_q, ansi_q, chv_q} <= {flush_d, gfx_d, alt_d, ansi_d, chv_d};
      {era_s_q, era_l_q, scr_q, err_q, id_req_q} <= {era_s_d, era_l_d, scr_d, err_d, id_req_d};
    end
  end

  logic [7:0] kbd_mem [4];
  logic [1:0] kbd_wr_q, kbd_wr_d, kbd_rd_q, kbd_rd_d, id_cnt_q, id_cnt_d;
  logic [2:0] kbd_cnt_q, kbd_cnt_d;
  logic       txv_q, txv_d, pend_q, pend_d, paused_q, paused_d;
  logic [7:0] txd_q, txd_d, pend_code_q, pend_code_d, id_char;
  logic       op_q, op_d, buf_q, buf_d, lock_q, lock_d, click_q, click_d, setup_q;
  logic       slot, key_in, kbd_pop, kbd_push, kbd_ovf, ctl_s, ctl_q;
  logic       op_set, op_clr, b_set, b_clr, xoff_req, xon_req;

  assign slot = !txv_q || i_tx_ready;
  assign id_char = (id_cnt_q == 2'h3) ? term_rx_pkg::CH_ESC :
                   (id_cnt_q == 2'h2) ? term_rx_pkg::CH_SLASH : term_rx_pkg::CH_IDENT;
  assign ctl_s  = i_key_valid && i_key_data == term_rx_pkg::CH_XOFF && i_automatic_flow_control;
  assign ctl_q  = i_key_valid && i_key_data == term_rx_pkg::CH_XON && i_automatic_flow_control;
  assign key_in = i_key_valid && !ctl_s && !ctl_q;
  assign op_set = i_automatic_flow_control && !op_q && (i_hold_key || ctl_s);
  assign op_clr = i_automatic_flow_control && op_q && (i_hold_key || ctl_q);
  assign b_set  = i_automatic_flow_control && !buf_q && cnt_q >= term_rx_pkg::XOFF_LVL && !flush_q;
  assign b_clr  = buf_q && cnt_q <= term_rx_pkg::XON_LVL && !flush_q && !i_flush_req;
  // Either hold alone owns the link; the other side adds no second code.
  assign xoff_req = (b_set && !op_q) || (op_set && !buf_q);
  assign xon_req  = (b_clr && !op_q) || (op_clr && !buf_q) ||
                    (i_flush_done && flush_q && i_automatic_flow_control && !op_q);

  always_comb begin
    kbd_wr_d = kbd_wr_q;
    kbd_rd_d = kbd_rd_q;
    kbd_cnt_d = kbd_cnt_q;
    id_cnt_d = id_cnt_q;
    txv_d = txv_q;
    txd_d = txd_q;
    pend_d = pend_q;
    pend_code_d = pend_code_q;
    paused_d = paused_q;
    op_d = op_q;
    buf_d = buf_q;
    lock_d = lock_q;
    kbd_pop = 1'b0;
    if (slot) begin
      txv_d = 1'b0;
      if (pend_q) begin
        txv_d = 1'b1;
        txd_d = pend_code_q;
        pend_d = 1'b0;
      end else if (!paused_q && id_cnt_q != 2'h0) begin
        txv_d = 1'b1;
        txd_d = id_char;
        id_cnt_d = id_cnt_q - 2'h1;
      end else if (!paused_q && kbd_cnt_q != 3'h0) begin
        txv_d = 1'b1;
        txd_d = kbd_mem[kbd_rd_q];
        kbd_pop = 1'b1;
      end
    end
    if (id_req_q && id_cnt_q == 2'h0) id_cnt_d = term_rx_pkg::ID_LEN;
    if (i_rx_valid && i_rx_data == term_rx_pkg::CH_XOFF) paused_d = 1'b1;
    if (i_rx_valid && i_rx_data == term_rx_pkg::CH_XON) paused_d = 1'b0;
    if (op_set) op_d = 1'b1;
    if (op_clr) op_d = 1'b0;
    if (b_set) buf_d = 1'b1;
    if (b_clr || i_flush_req || flush_q) buf_d = 1'b0;
    if (!i_automatic_flow_control) begin
      op_d = 1'b0;
      buf_d = 1'b0;
    end
    if (xoff_req) begin
      pend_d = 1'b1;
      pend_code_d = term_rx_pkg::CH_XOFF;
    end else if (xon_req) begin
      pend_d = 1'b1;
      pend_code_d = term_rx_pkg::CH_XON;
    end
    kbd_push = key_in && (kbd_cnt_q != term_rx_pkg::KBD_FULL || kbd_pop);
    kbd_ovf  = key_in && kbd_cnt_q == term_rx_pkg::KBD_FULL && !kbd_pop;
    if (kbd_push) kbd_wr_d = kbd_wr_q + 2'h1;
    if (kbd_pop) kbd_rd_d = kbd_rd_q + 2'h1;
    if (kbd_push && !kbd_pop) kbd_cnt_d = kbd_cnt_q + 3'h1;
    if (kbd_pop && !kbd_push) kbd_cnt_d = kbd_cnt_q - 3'h1;
    if (i_setup_mode != setup_q) lock_d = 1'b0;
    if (kbd_ovf) lock_d = 1'b1;
    click_d = !lock_d;
  end

  always_ff @(posedge i_clk) begin
    if (kbd_push) kbd_mem[kbd_wr_q] <= i_key_data;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      {kbd_wr_q, kbd_rd_q, kbd_cnt_q, id_cnt_q} <= 9'h000;
      {txd_q, pend_code_q} <= 16'h0000;
      {txv_q, pend_q, paused_q, op_q, buf_q, lock_q, setup_q} <= 7'h00;
      click_q <= 1'b1;
    end else begin
      {kbd_wr_q, kbd_rd_q, kbd_cnt_q, id_cnt_q} <= {kbd_wr_d, kbd_rd_d, kbd_cnt_d, id_cnt_d};
      {txd_q, pend_code_q} <= {txd_d, pend_code_d};
      {txv_q, pend_q, paused_q, op_q, buf_q, lock_q} <= {txv_d, pend_d, paused_d, op_d, buf_d, lock_d};
      {click_q, setup_q} <= {click_d, i_setup_mode};
    end
  end

  assign o_tx_valid = txv_q;
  assign o_tx_data = txd_q;
  assign o_char_valid = chv_q;
  assign o_char_data = ch_q;
  assign o_cursor_row = row_q;
  assign o_cursor_col = col_q;
  assign o_glyph_graphics = gfx_q;
  assign o_alt_keypad = alt_q;
  assign o_ansi_mode = ansi_q;
  assign o_erase_screen = era_s_q;
  assign o_erase_line = era_l_q;
  assign o_scroll_down = scr_q;
  assign o_error_glyph = err_q;
  assign o_keyboard_locked_indicator = lock_q;
  assign o_key_click_en = click_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_id_start;
    id_req_q && id_cnt_q == 2'h0;
  endsequence
  chk_fifo_bound: assert property (cnt_q <= term_rx_pkg::RX_FULL) else $error("rx count past capacity");
  chk_overflow_glyph: assert property (rx_ok && cnt_q == term_rx_pkg::RX_FULL && !flush_q |=>
    o_error_glyph && cnt_q <= term_rx_pkg::RX_FULL) else $error("overflow not flagged");
  chk_xoff_level: assert property (b_set && !op_q |=> pend_q && pend_code_q == term_rx_pkg::CH_XOFF)
    else $error("no XOFF at fill level");
  chk_xon_level: assert property (b_clr && !op_q |=> pend_q && pend_code_q == term_rx_pkg::CH_XON)
    else $error("no XON at drain level");
  chk_paused_flow: assert property (paused_q && slot && !pend_q |=> !o_tx_valid)
    else $error("sent while held");
  chk_lock_ovf: assert property (kbd_ovf |=> o_keyboard_locked_indicator && !o_key_click_en)
    else $error("overflow did not lock");
  chk_setup_unlock: assert property (i_setup_mode != setup_q && !kbd_ovf |=> !o_keyboard_locked_indicator)
    else $error("set-up change kept lock");
  chk_setup_stall: assert property (i_setup_mode |=> cnt_q >= $past(cnt_q) || $past(flush_q || i_flush_req))
    else $error("drained in set-up");
  chk_up_clamp: assert property (pop && st_q == term_rx_pkg::ST_ESC && rx_head == term_rx_pkg::CH_UP &&
    o_cursor_row == term_rx_pkg::ROW_TOP |=> o_cursor_row == term_rx_pkg::ROW_TOP) else $error("up passed top");
  chk_id_start: assert property (s_id_start |=> id_cnt_q == term_rx_pkg::ID_LEN)
    else $error("identify not started");
endmodule

// *** host_model.sv ***
// Host computer model on the far side of the terminal's serial link.
// Assumes characters to the terminal cross as single-cycle strobes on the terminal clock; characters from it wait on ready.
`timescale 1ns/100ps
module host_model (
  input  logic       i_clk,
  input  logic       i_tx_valid,
  input  logic [7:0] i_tx_data,
  output logic       o_rx_valid,
  output logic [7:0] o_rx_data,
  output logic       o_tx_ready
);
  logic [7:0] got[$];
  logic [1:0] stall_q   = 2'h0;
  bit         term_xoff = 1'b0;
  bit         host_held = 1'b0;
  int         bad_count = 0;
  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'h00;
  end
  // The host stalls one cycle in four so held characters must stand.
  assign o_tx_ready = (stall_q != 2'h3);
  always @(posedge i_clk) begin
    stall_q <= stall_q + 2'h1;
    if (i_tx_valid && o_tx_ready) begin
      got.push_back(i_tx_data);
      if (i_tx_data == 8'h13) term_xoff = 1'b1;
      if (i_tx_data == 8'h11) term_xoff = 1'b0;
      if (host_held && i_tx_data != 8'h13 && i_tx_data != 8'h11) bad_count++;
    end
  end
  // Waits out a terminal hold unless the caller means to overrun the buffer.
  task automatic send(input logic [7:0] c, input bit overrun);
    int n;
    n = 0;
    while (term_xoff && !overrun && n < 5000) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_data  <= c;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data  <= ~c;
    if (c == 8'h13) host_held = 1'b1;
    if (c == 8'h11) host_held = 1'b0;
  endtask
  task automatic hold_for_reset();
    term_xoff = 1'b1;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the terminal receive and flow control block.
// Assumes host_model stands on the serial side; the bench plays keyboard and operator.
`timescale 1ns/100ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        key_v = 1'b0;
  logic [7:0]  key_d = 8'h00;
  logic        hold = 1'b0;
  logic        auto_fc = 1'b1;
  logic        setup = 1'b0;
  logic        fl_req = 1'b0;
  logic        fl_done = 1'b0;
  logic        rx_v, tx_v, tx_rdy, cv, gfx, alt, ansi, es, el, scr, errg, lock, click;
  logic [7:0]  rx_d, tx_d, cd;
  logic [4:0]  row;
  logic [6:0]  col;
  logic [6:0]  er = 7'h01;
  logic [6:0]  ec = 7'h01;
  logic [31:0] seed = 32'h849C146C;
  logic [31:0] r;
  logic [7:0]  shown[$];
  int          err_count = 0;
  int          checked = 0;
  int          n_es = 0;
  int          n_el = 0;
  int          n_scr = 0;
  int          n_err = 0;
  always #20 clk = ~clk;
  host_model host_u (.i_clk(clk), .i_tx_valid(tx_v), .i_tx_data(tx_d), .o_rx_valid(rx_v), .o_rx_data(rx_d),
                     .o_tx_ready(tx_rdy));
  legacy_escape_rx_flow_control dut_u (.i_clk(clk), .i_rst(rst), .i_rx_valid(rx_v), .i_rx_data(rx_d),
    .i_tx_ready(tx_rdy), .i_key_valid(key_v), .i_key_data(key_d), .i_hold_key(hold),
    .i_automatic_flow_control(auto_fc), .i_setup_mode(setup), .i_flush_req(fl_req), .i_flush_done(fl_done),
    .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_char_valid(cv), .o_char_data(cd), .o_cursor_row(row),
    .o_cursor_col(col), .o_glyph_graphics(gfx), .o_alt_keypad(alt), .o_ansi_mode(ansi), .o_erase_screen(es),
    .o_erase_line(el), .o_scroll_down(scr), .o_error_glyph(errg), .o_keyboard_locked_indicator(lock),
    .o_key_click_en(click));
  always @(posedge clk) begin
    if (es) n_es++;
    if (el) n_el++;
    if (scr) n_scr++;
    if (errg) n_err++;
    if (cv) shown.push_back(cd);
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Decodes an addressing byte and clamps it to the screen.
  function automatic logic [6:0] addr_val(input logic [7:0] b, input logic [6:0] top);
    if (b <= 8'h1F) return 7'h01;
    if (b - 8'h1F > {1'b0, top}) return top;
    return 7'(b - 8'h1F);
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic esc(input logic [7:0] c);
    host_u.send(8'h1B, 1'b0);
    host_u.send(c, 1'b0);
    repeat (4) @(posedge clk);
  endtask
  task automatic move(input logic [7:0] c);
    esc(c);
    case (c)
      8'h41: if (er > 7'h01) er--;
      8'h42: if (er < 7'h18) er++;
      8'h43: if (ec < 7'h50) ec++;
      default: if (ec > 7'h01) ec--;
    endcase
  endtask
  task automatic go_to(input logic [7:0] rb, input logic [7:0] cb);
    host_u.send(8'h1B, 1'b0);
    host_u.send(8'h59, 1'b0);
    host_u.send(rb, 1'b0);
    host_u.send(cb, 1'b0);
    repeat (4) @(posedge clk);
    er = addr_val(rb, 7'h18);
    ec = addr_val(cb, 7'h50);
  endtask
  task automatic pos_ok();
    check("row", {3'h0, row}, {1'b0, er});
    check("col", {1'b0, col}, {1'b0, ec});
  endtask
  task automatic expect_tx(input logic [7:0] b);
    int n;
    n = 0;
    while (host_u.got.size() == 0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    if (host_u.got.size() == 0) check("tx present", 8'h00, 8'h01);
    else check("tx byte", host_u.got.pop_front(), b);
  endtask
  task automatic pulse(input int which, input logic [7:0] k);
    @(posedge clk);
    case (which)
      0: hold <= 1'b1;
      1: fl_req <= 1'b1;
      2: fl_done <= 1'b1;
      default: key_v <= 1'b1;
    endcase
    key_d <= k;
    @(posedge clk);
    hold <= 1'b0;
    fl_req <= 1'b0;
    fl_done <= 1'b0;
    key_v <= 1'b0;
  endtask
  task automatic fill(input int cnt);
    for (int i = 0; i < cnt; i++) host_u.send(8'h30 + 8'(i), 1'b1);
    repeat (4) @(posedge clk);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("click", {7'h0, click}, 8'h01);
    go_to(8'h22, 8'h24);
    pos_ok();
    esc(8'h49);
    er = 7'h02;
    pos_ok();
    esc(8'h48);
    er = 7'h01;
    ec = 7'h01;
    pos_ok();
    esc(8'h49);
    check("scroll", 8'(n_scr), 8'h01);
    move(8'h41);
    move(8'h44);
    pos_ok();
    go_to(8'h37, 8'h6F);
    move(8'h42);
    move(8'h43);
    pos_ok();
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      if (r[4:2] == 3'h0) go_to(8'h1C + {3'h0, r[12:8]}, 8'h1C + {1'b0, r[22:16]});
      else move(8'h41 + {6'h0, r[1:0]});
      pos_ok();
    end
    esc(8'h4A);
    esc(8'h4B);
    check("erase", 8'(n_es + n_el), 8'h02);
    pos_ok();
    esc(8'h46);
    check("gfx", {7'h0, gfx}, 8'h01);
    esc(8'h47);
    check("gfx", {7'h0, gfx}, 8'h00);
    esc(8'h3D);
    check("alt", {7'h0, alt}, 8'h01);
    esc(8'h3E);
    check("alt", {7'h0, alt}, 8'h00);
    esc(8'h31);
    esc(8'h78);
    check("modes", {6'h0, gfx, alt}, 8'h00);
    pos_ok();
    esc(8'h5A);
    expect_tx(8'h1B);
    expect_tx(8'h2F);
    expect_tx(8'h5A);
    shown.delete();
    setup <= 1'b1;
    fill(65);
    expect_tx(8'h13);
    check("error", 8'(n_err), 8'h01);
    check("popped", 8'(shown.size()), 8'h00);
    setup <= 1'b0;
    expect_tx(8'h11);
    repeat (80) @(posedge clk);
    check("count", 8'(shown.size()), 8'h40);
    for (int i = 0; i < 64; i++) check("order", shown[i], 8'h30 + 8'(i));
    host_u.send(8'h13, 1'b1);
    for (int i = 0; i < 5; i++) pulse(3, 8'h61 + 8'(i));
    repeat (3) @(posedge clk);
    check("lock", {6'h0, lock, click}, 8'h02);
    check("held tx", 8'(host_u.got.size()), 8'h00);
    setup <= 1'b1;
    repeat (3) @(posedge clk);
    setup <= 1'b0;
    repeat (3) @(posedge clk);
    check("lock", {7'h0, lock}, 8'h00);
    host_u.send(8'h11, 1'b1);
    for (int i = 0; i < 4; i++) expect_tx(8'h61 + 8'(i));
    check("held bad", 8'(host_u.bad_count), 8'h00);
    shown.delete();
    host_u.hold_for_reset();
    pulse(1, 8'h00);
    host_u.send(8'h41, 1'b1);
    pulse(2, 8'h00);
    expect_tx(8'h11);
    check("flushed", 8'(shown.size()), 8'h00);
    setup <= 1'b1;
    fill(32);
    expect_tx(8'h13);
    pulse(0, 8'h00);
    setup <= 1'b0;
    repeat (80) @(posedge clk);
    check("merged", 8'(host_u.got.size()), 8'h00);
    pulse(0, 8'h00);
    expect_tx(8'h11);
    auto_fc <= 1'b0;
    pulse(0, 8'h00);
    pulse(3, 8'h13);
    expect_tx(8'h13);
    pulse(3, 8'h11);
    expect_tx(8'h11);
    setup <= 1'b1;
    fill(40);
    check("no xoff", 8'(host_u.got.size()), 8'h00);
    setup <= 1'b0;
    repeat (60) @(posedge clk);
    go_to(8'h24, 8'h24);
    esc(8'h3C);
    check("ansi", {7'h0, ansi}, 8'h01);
    esc(8'h41);
    pos_ok();
    wrap_up();
  end
endmodule
